/* File: src/sdrb_ctrl.sv */
// Controller for a four-bank 64K byte dynamic RAM board on a parallel bus.
// Assumes bus pins arrive asynchronously and the master issues refresh cycles.
// Contract
// R01: Master keeps a 7-bit refresh row counter advanced after each fetch.
// R02: Refresh strobe with memory request makes the board run a row refresh.
// R03: All 128 rows must be refreshed within every 2 ms.
// R04: Interrupt acknowledge adds only two wait states, leaving refresh intact.
// R05: A DMA controller holding the bus must issue refresh itself.
// R06: Wait-state inserters must keep refresh gaps within 2 ms.
// R07: Write data buffers are always enabled toward the RAM array.
// R08: Read drivers enable only when the read gate is true.
// R09: Gate false blocks read data but writes still complete.
// R10: PHANTOM low suppresses read data for an overlaying ROM.
// R11: Bootstrap holds PHANTOM low, copies ROM, then releases it.
// R12: Row then column address presented on the same seven lines.
// R13: Read data is sampled before the column strobe is released.
// R14: Refresh uses row-strobe-only cycles without a column strobe.
// R15: Four strapped banks selected by the two top address bits.
// R16: Row strobe, delayed mux switch, then column strobe; refresh skips it.
// R17: A bank with its strap removed ignores reads and writes.
`timescale 1ns/1ps
`default_nettype none
module sdrb_ctrl
  import sdrb_pkg::*;
#(
  parameter int REFRESH_LIMIT = REFRESH_PERIOD_CYC
) (
  input wire logic clk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire sdrb_bus_type bus_in, // Bus pins, asynchronous.
  input wire logic [BANK_COUNT-1:0] bank_strap, // Bank enable straps.
  input wire logic [7:0] dram_dout, // Data out of the addressed bank.
  output sdrb_dram_type dram_out, // DRAM array drive.
  output logic [7:0] read_data, // Read data toward the bus.
  output logic read_data_oe, // Read driver enable.
  output logic refresh_overdue // Row gap exceeded the refresh period.
);
  typedef enum {ST_IDLE, ST_RAS, ST_COL, ST_CAS, ST_REF, ST_PRE} sdrb_state_type;

  typedef struct packed {
    sdrb_state_type state;
    logic [TIMER_W-1:0] timer;
    logic [1:0] bank;
    logic is_write;
    logic col_sel;
    logic [BANK_COUNT-1:0] ras_n;
    logic [BANK_COUNT-1:0] cas_n;
    logic write_n;
    logic [7:0] rdata;
    logic rvalid;
    logic [31:0] gap;
    logic overdue;
  } sdrb_regs_type;

  sdrb_bus_type bus_s;
  sdrb_regs_type st_reg;
  sdrb_regs_type st_next;
  logic read_gate;
  logic bank_hit;
  logic [BANK_COUNT-1:0] strap_s;

  sdrb_sync #(.WIDTH($bits(sdrb_bus_type))) u_sync (
    .clk(clk),
    .async_in(bus_in),
    .sync_out(bus_s)
  );

  // Straps are jumpers outside the clock domain, so they take the same two flops as the bus.
  sdrb_sync #(.WIDTH(BANK_COUNT)) u_strap_sync (
    .clk(clk),
    .async_in(bank_strap),
    .sync_out(strap_s)
  );

  function automatic logic [BANK_COUNT-1:0] bank_onehot(input logic [1:0] b);
    bank_onehot = 4'h1 << b;
  endfunction

  // R15 bank decode
  assign bank_hit = strap_s[bus_s.addr[15:14]];

  // R08 read gate
  // R10 overlay suppress
  // R17 disabled bank quiet
  assign read_gate = bus_s.pdbin & bus_s.smemr & bus_s.memory_access_request
                     & bus_s.phantom & bank_hit & ~bus_s.refresh_strobe;

  always_comb begin
    st_next = st_reg;
    st_next.timer = st_reg.timer - 8'h01;
    st_next.gap = (st_reg.gap == 32'hffffffff) ? st_reg.gap : st_reg.gap + 32'h1;
    if (st_reg.gap >= 32'(REFRESH_LIMIT)) begin
      st_next.overdue = 1'b1;
    end
    if (!read_gate) begin
      st_next.rvalid = 1'b0;
    end
    case (st_reg.state)
      ST_IDLE: begin
        if (bus_s.memory_access_request && bus_s.refresh_strobe) begin
          // R02 refresh cycle
          st_next.state = ST_REF;
          st_next.ras_n = 4'h0;
          st_next.col_sel = 1'b0;
          st_next.timer = 8'(RAS_ONLY_CYC);
          st_next.gap = 32'h0;
        end else if (bus_s.memory_access_request && bank_hit
                     && (bus_s.smemr || bus_s.write_strobe)) begin
          // R16 row strobe first
          st_next.state = ST_RAS;
          st_next.bank = bus_s.addr[15:14];
          st_next.is_write = bus_s.write_strobe;
          st_next.ras_n = ~bank_onehot(bus_s.addr[15:14]);
          st_next.col_sel = 1'b0;
          st_next.timer = 8'(RAS_TO_MUX_CYC);
        end
      end
      ST_RAS: begin
        if (st_reg.timer == 8'h01) begin
          // R12 switch to column
          st_next.col_sel = 1'b1;
          st_next.state = ST_COL;
          st_next.timer = 8'(MUX_TO_CAS_CYC);
        end
      end
      ST_COL: begin
        if (st_reg.timer == 8'h01) begin
          st_next.cas_n = st_reg.ras_n;
          st_next.write_n = ~st_reg.is_write;
          st_next.state = ST_CAS;
          st_next.timer = 8'(CAS_WIDTH_CYC);
        end
      end
      ST_CAS: begin
        if (st_reg.timer == 8'h01) begin
          // R13 sample under column strobe
          if (!st_reg.is_write) begin
            st_next.rdata = dram_dout;
            st_next.rvalid = read_gate;
          end
          st_next.state = ST_PRE;
          st_next.timer = 8'(PRECHARGE_CYC);
          st_next.ras_n = 4'hf;
          st_next.cas_n = 4'hf;
          st_next.write_n = 1'b1;
        end
      end
      ST_REF: begin
        // R14 row strobe only
        if (st_reg.timer == 8'h01) begin
          st_next.ras_n = 4'hf;
          st_next.state = ST_PRE;
          st_next.timer = 8'(PRECHARGE_CYC);
        end
      end
      ST_PRE: begin
        if (st_reg.timer == 8'h01 && !bus_s.memory_access_request) begin
          st_next.state = ST_IDLE;
        end else if (st_reg.timer == 8'h01) begin
          st_next.timer = 8'h01;
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '{state: ST_IDLE, timer: 8'h00, bank: 2'h0, is_write: 1'b0,
                  col_sel: 1'b0, ras_n: 4'hf, cas_n: 4'hf, write_n: 1'b1,
                  rdata: 8'h00, rvalid: 1'b0, gap: 32'h0, overdue: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // R12 multiplexed address
  assign dram_out.dram_addr = st_reg.col_sel ? bus_s.addr[13:7] : bus_s.addr[6:0];
  assign dram_out.ras_n = st_reg.ras_n;
  assign dram_out.cas_n = st_reg.cas_n;
  assign dram_out.write_n = st_reg.write_n;
  // R07 write buffers always on
  assign dram_out.din = bus_s.write_data;
  // R09 drive only while gated
  assign read_data_oe = st_reg.rvalid & read_gate;
  assign read_data = st_reg.rdata;
  // R03 refresh interval monitor
  assign refresh_overdue = st_reg.overdue;

  a_refresh_no_cas: assert property (@(posedge clk) disable iff (srst) // R14
    st_reg.state == ST_REF |-> st_reg.cas_n == 4'hf)
    else $error("column strobe active during refresh");

  sequence s_row_open;
    st_reg.state == ST_RAS && st_reg.col_sel == 1'b0;
  endsequence
  a_row_before_col: assert property (@(posedge clk) disable iff (srst) // R16
    $rose(st_reg.state == ST_COL) |-> $past(st_reg.state) == ST_RAS && st_reg.col_sel)
    else $error("column phase not preceded by row phase");

  a_row_mux_delay: assert property (@(posedge clk) disable iff (srst) // R16
    $rose(st_reg.state == ST_RAS) |-> s_row_open [*3] ##1 st_reg.col_sel)
    else $error("row address not held before column switch");

  a_cas_after_mux: assert property (@(posedge clk) disable iff (srst) // R12
    $fell(|(~st_reg.cas_n)) |-> $past(st_reg.col_sel))
    else $error("column strobe ended without column address");

  a_oe_gated: assert property (@(posedge clk) disable iff (srst) // R08
    read_data_oe |-> bus_s.pdbin && bus_s.smemr && bus_s.memory_access_request)
    else $error("read drivers on without gate");

  a_phantom_quiet: assert property (@(posedge clk) disable iff (srst) // R10
    !bus_s.phantom |-> !read_data_oe ##1 !st_reg.rvalid)
    else $error("read data driven while overlay active");

  a_strap_quiet: assert property (@(posedge clk) disable iff (srst) // R17
    (st_reg.state == ST_IDLE && !bank_hit && !bus_s.refresh_strobe)
    |=> st_reg.state != ST_RAS)
    else $error("disabled bank started an access");

  a_write_passes: assert property (@(posedge clk) disable iff (srst) // R07
    dram_out.din == bus_s.write_data)
    else $error("write buffer not transparent");

  a_write_in_cas: assert property (@(posedge clk) disable iff (srst) // R09
    !dram_out.write_n |-> st_reg.is_write && dram_out.cas_n != 4'hf)
    else $error("write strobe outside a write column phase");

  a_sample_timing: assert property (@(posedge clk) disable iff (srst) // R13
    $rose(st_reg.rvalid) |-> $past(st_reg.state) == ST_CAS && $past(st_reg.cas_n) != 4'hf)
    else $error("read data sampled outside column strobe");

  a_refresh_start: assert property (@(posedge clk) disable iff (srst) // R02
    (st_reg.state == ST_IDLE && bus_s.memory_access_request && bus_s.refresh_strobe)
    |=> st_reg.state == ST_REF && st_reg.ras_n == 4'h0 ##1 st_reg.gap == 32'h1)
    else $error("refresh request not served");

  a_gap_flag: assert property (@(posedge clk) disable iff (srst) // R03
    st_reg.gap >= 32'(REFRESH_LIMIT) |=> refresh_overdue)
    else $error("refresh gap overrun not flagged");
endmodule
`default_nettype wire

/* File: src/sdrb_pkg.sv */
// Shared constants and carrier types for the dynamic RAM board controller.
// Assumes a 100 MHz system clock and synchronous active-high reset.
package sdrb_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROW_BITS = 7;
  localparam int BANK_COUNT = 4;
  localparam int REFRESH_ROWS = 128;
  localparam int REFRESH_PERIOD_NS = 2000000;
  localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RAS_TO_MUX_NS = 30;
  localparam int RAS_TO_MUX_CYC = (RAS_TO_MUX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MUX_TO_CAS_NS = 10;
  localparam int MUX_TO_CAS_CYC = (MUX_TO_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_WIDTH_NS = 100;
  localparam int CAS_WIDTH_CYC = (CAS_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_ONLY_NS = 150;
  localparam int RAS_ONLY_CYC = (RAS_ONLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_NS = 100;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 8;

  typedef struct packed {
    logic [15:0] addr;
    logic memory_access_request;
    logic refresh_strobe;
    logic pdbin;
    logic smemr;
    logic write_strobe;
    logic phantom;
    logic [7:0] write_data;
  } sdrb_bus_type;

  typedef struct packed {
    logic [ROW_BITS-1:0] dram_addr;
    logic [BANK_COUNT-1:0] ras_n;
    logic [BANK_COUNT-1:0] cas_n;
    logic write_n;
    logic [7:0] din;
  } sdrb_dram_type;
endpackage

/* File: src/sdrb_sync.sv */
// Two-flop synchroniser for a vector of bus pins.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module sdrb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // System clock.
  input wire logic [WIDTH-1:0] async_in, // Pin levels.
  output logic [WIDTH-1:0] sync_out // Synchronised levels.
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk) begin
    meta_reg <= async_in;
    sync_out <= meta_reg;
  end
endmodule
`default_nettype wire

/* File: testbench/sdrb_dram_model.sv */
// Behavioural model of the four DRAM banks behind the controller.
// Assumes registered active-low strobes that settle before the falling edge.
`timescale 1ns/1ps
`default_nettype none
module sdrb_dram_model
  import sdrb_pkg::*;
(
  input wire logic clk, // System clock.
  input wire sdrb_dram_type dram, // Array drive.
  output logic [7:0] dout, // Bank data.
  output int cas_pulses // Column strobes seen.
);
  logic [7:0] mem [0:65535];
  logic [6:0] row [0:3];
  logic [6:0] col [0:3];
  logic [3:0] ras_q = 4'hf;
  logic [3:0] cas_q = 4'hf;
  logic driven;
  initial begin
    dout = 8'h00;
    cas_pulses = 0;
    forever begin
      @(negedge clk);
      driven = 1'b0;
      for (int b = 0; b < 4; b++) begin
        if (ras_q[b] && !dram.ras_n[b]) row[b] = dram.dram_addr;
        if (cas_q[b] && !dram.cas_n[b]) begin
          col[b] = dram.dram_addr;
          cas_pulses++;
        end
        if (!dram.cas_n[b] && !dram.ras_n[b]) begin
          if (!dram.write_n) mem[{2'(b), col[b], row[b]}] = dram.din;
          dout = mem[{2'(b), col[b], row[b]}];
          driven = 1'b1;
        end
      end
      if (!driven) dout = ~dout;
      ras_q = dram.ras_n;
      cas_q = dram.cas_n;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_s100_dram_board_refresh_gating.sv */
// Self-checking bench for the DRAM board controller, acting as bus master.
// Assumes the DRAM model answers behind the controller's array port.
`timescale 1ns/1ps
`default_nettype none
module tb_s100_dram_board_refresh_gating;
  import sdrb_pkg::*;
  logic clk, srst, read_data_oe, refresh_overdue;
  sdrb_bus_type bus;
  logic [3:0] bank_strap;
  logic [7:0] dram_dout, read_data, d;
  sdrb_dram_type dram_out;
  logic [15:0] a;
  logic [6:0] refresh_row;
  logic cas_low_q = 1'b0;
  int cas_pulses, n_fail = 0, comparisons = 0;
  logic [8:0] notes [$];

  sdrb_ctrl #(.REFRESH_LIMIT(500)) dut (.clk(clk), .srst(srst), .bus_in(bus),
    .bank_strap(bank_strap), .dram_dout(dram_dout), .dram_out(dram_out),
    .read_data(read_data), .read_data_oe(read_data_oe), .refresh_overdue(refresh_overdue));
  sdrb_dram_model dram_array (.clk(clk), .dram(dram_out), .dout(dram_dout),
    .cas_pulses(cas_pulses));

  always #5 clk = ~clk;

  task automatic check(input logic [8:0] seen, input logic [8:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Results appear when the column strobe ends; the oldest note is compared.
  always @(negedge clk) begin
    if (cas_low_q && dram_out.cas_n === 4'hf) begin
      if (notes.size() == 0) check(9'h1ff, 9'h000, "stray cycle");
      else check({read_data_oe, read_data_oe ? read_data : 8'h00}, notes.pop_front(),
        "read result");
    end
    cas_low_q = (dram_out.cas_n !== 4'hf);
  end

  task automatic access(input logic [15:0] ad, input logic wr, input logic [7:0] wd,
                        input logic ph, input logic [8:0] want);
    int n, c0;
    @(posedge clk);
    c0 = cas_pulses;
    if (bank_strap[ad[15:14]]) notes.push_back(want);
    bus.addr <= ad;
    bus.write_data <= wd;
    bus.write_strobe <= wr;
    bus.smemr <= !wr;
    bus.pdbin <= !wr;
    bus.phantom <= ph;
    bus.memory_access_request <= 1'b1;
    for (n = 0; n < 20 && dram_out.ras_n === 4'hf; n++) @(negedge clk);
    if (bank_strap[ad[15:14]]) begin
      check({2'b00, dram_out.dram_addr}, {2'b00, ad[6:0]}, "row half");
      for (n = 0; n < 20 && dram_out.cas_n === 4'hf; n++) @(negedge clk);
      check(9'(n), 9'(RAS_TO_MUX_CYC + MUX_TO_CAS_CYC), "row to column delay");
      check({2'b00, dram_out.dram_addr}, {2'b00, ad[13:7]}, "column half");
      for (n = 0; n < 20 && dram_out.cas_n !== 4'hf; n++) @(negedge clk);
      check(9'(n), 9'(CAS_WIDTH_CYC), "column strobe width");
    end else begin
      check({dram_out.ras_n, 5'(cas_pulses - c0)}, 9'h1e0, "strap ignored");
    end
    @(posedge clk);
    bus.memory_access_request <= 1'b0;
    bus.pdbin <= 1'b0;
    bus.smemr <= 1'b0;
    bus.write_strobe <= 1'b0;
    repeat (4) @(negedge clk);
    check({8'h00, read_data_oe}, 9'h000, "driver released");
    repeat (10) @(posedge clk);
  endtask

  task automatic refresh();
    int n, c0;
    @(posedge clk);
    c0 = cas_pulses;
    bus.addr <= {9'h000, refresh_row};
    bus.refresh_strobe <= 1'b1;
    bus.memory_access_request <= 1'b1;
    for (n = 0; n < 20 && dram_out.ras_n !== 4'h0; n++) @(negedge clk);
    check({5'h00, dram_out.ras_n}, 9'h000, "refresh row strobe");
    check({2'b00, dram_out.dram_addr}, {2'b00, refresh_row}, "refresh row");
    for (n = 0; n < 30 && dram_out.ras_n !== 4'hf; n++) @(negedge clk);
    check(9'(n), 9'(RAS_ONLY_CYC), "refresh length");
    check(9'(cas_pulses - c0), 9'h000, "refresh column strobe");
    @(posedge clk);
    bus.refresh_strobe <= 1'b0;
    bus.memory_access_request <= 1'b0;
    refresh_row = refresh_row + 7'h01;
    repeat (12) @(posedge clk);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    bus = '0;
    bus.phantom = 1'b1;
    bank_strap = 4'hf;
    refresh_row = 7'h00;
    void'($urandom(31750));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      a = 16'($urandom());
      d = 8'($urandom());
      access(a, 1'b1, d, 1'b1, 9'h000);
      access(a, 1'b0, 8'h00, 1'b1, {1'b1, d});
      refresh();
    end
    access(16'h0040, 1'b1, 8'h3c, 1'b0, 9'h000);
    access(16'h0040, 1'b0, 8'h00, 1'b0, 9'h000);
    access(16'h0040, 1'b0, 8'h00, 1'b1, {1'b1, 8'h3c});
    access(16'h8123, 1'b1, 8'h5a, 1'b1, 9'h000);
    bank_strap <= 4'b1011;
    access(16'h8123, 1'b1, 8'ha5, 1'b1, 9'h000);
    access(16'h8123, 1'b0, 8'h00, 1'b1, 9'h000);
    bank_strap <= 4'hf;
    access(16'h8123, 1'b0, 8'h00, 1'b1, {1'b1, 8'h5a});
    for (int i = 0; i < 128; i++) refresh();
    check({8'h00, refresh_overdue}, 9'h000, "refresh gap");
    repeat (520) @(posedge clk);
    check({8'h00, refresh_overdue}, 9'h001, "missed refresh");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({8'h00, refresh_overdue}, 9'h000, "flag after reset");
    check(9'(notes.size()), 9'h000, "results missing");
    conclude();
  end
endmodule
`default_nettype wire
